// file: hw/dcmp_defines.svh
// Register offsets, field positions, reset values for the comparator block
`ifndef DCMP_DEFINES_SVH
`define DCMP_DEFINES_SVH
`define DCMP_ADR_W 5
`define DCMP_OFF_CTRL 5'h00
`define DCMP_OFF_REQ2 5'h04
`define DCMP_OFF_EN2 5'h08
`define DCMP_OFF_INTC 5'h0c
`define DCMP_OFF_DIR 5'h10
`define DCMP_OFF_CONV1 5'h14
`define DCMP_OFF_PORT 5'h18
`define DCMP_BIT_RES2 7
`define DCMP_BIT_RES1 6
`define DCMP_BIT_INV2 5
`define DCMP_BIT_INV1 4
`define DCMP_BIT_CIS 3
`define DCMP_BIT_FLAG 6
`define DCMP_BIT_COMPARATOR_IRQ_ENABLE 6
`define DCMP_BIT_GIE 7
`define DCMP_BIT_PERIPHERAL_IRQ_ENABLE 6
`define DCMP_MODE_OFF 3'h7
`define DCMP_MODE_FOUR 3'h6
`define DCMP_CTRL_RST 6'h07
`define DCMP_DIR_RST 6'h3f
`define DCMP_PCFG_RST 4'h0
`endif

// file: hw/dcmp_pkg.sv
// Types shared by the comparator block
package dcmp_pkg;
   typedef struct packed {
      logic inv2;
      logic inv1;
      logic input_switch_select;
      logic [2:0] mode;
   } dcmp_ctrl_type;
   typedef struct packed {
      logic pos_from_ref;
      logic neg_from_ref_pins;
      logic [1:0] cmp_on;
   } dcmp_amux_type;
endpackage

// file: hw/dcmp_core.sv
// Comparator digital side: results, pin routing, change flag, Wishbone registers
// Contract
// - Positive below negative gives low result.
// - Internal reference feeds positive inputs, mode 110.
// - Both results readable, read-only, in control.
// - Routing sends raw results straight to pins.
// - Direction bits still enable routed pin drivers.
// - Per-comparator inversion bits at 5 and 4.
// - Flag sets on any result change.
// - Flag sticky; software writes one to set.
// - Interrupt needs three enables; flag sets regardless.
// - Change during control read may lose flag.
// - Any control access clears the mismatch.
// - Persisting mismatch keeps setting the flag.
// - Comparators run in sleep, interrupt wakes.
// - Mode 111 switches both comparators off.
// - Waking leaves control register unchanged.
// - Reset loads control with mode all-off.
// - Shared pins reset analog, set by config.
// - Port read gives zero for analog pins.
// - Mode field selects one of eight configurations.
// - Input switch picks negative input sources in mode 110.
//
// Register access over Wishbone and the register offsets were decided locally.
`timescale 1ns/1ps
`include "dcmp_defines.svh"
module dcmp_core
   import dcmp_pkg::*;
#(
   parameter logic [7:0] MODE_ON1 = 8'h7f,
   parameter logic [7:0] MODE_ON2 = 8'h7f,
   parameter logic [7:0] MODE_ROUTE = 8'h00
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [`DCMP_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [1:0] cmp_above,
   input wire logic [5:0] port_pin_in,
   output logic first_output_pin,
   output logic first_output_pin_oe,
   output logic second_output_pin,
   output logic second_output_pin_oe,
   output dcmp_amux_type amux,
   output logic [3:0] pin_analog,
   output logic irq,
   output logic wake
);
   ////////////////////////////////////////////////////////////////////////////
   // Mode 111 must stay off in any mapping
   if (MODE_ON1[7] || MODE_ON2[7] || MODE_ROUTE[7]) begin : g_chk
      $error("mode 111 must leave both comparators off");
   end

   dcmp_ctrl_type ctrl_r;
   logic [1:0] above_s1_r, above_s2_r;
   logic [1:0] seen_r;
   logic flag_r, comparator_irq_enable_r, gie_r, peripheral_irq_enable_r;
   logic [5:0] dir_r;
   logic [3:0] pcfg_r;
   logic [5:0] pin_s1_r, pin_s2_r;
   logic ack_r;
   logic [31:0] rdat_r;
   logic [1:0] age_r;
   logic req, acc, wr, rd, ctrl_acc, ctrl_rd;
   logic [1:0] on, res, raw_res, mism;
   logic [31:0] rdat_nxt;

   // Comparator result: high when positive above negative, then inverted
   function automatic logic [1:0] cmp_res(input logic [1:0] above, input dcmp_ctrl_type c,
                                          input logic [1:0] en);
      cmp_res = (above ^ {c.inv2, c.inv1}) & en;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode; an access takes effect at the edge that sees ack high
   assign req = wb_cyc_i & wb_stb_i;
   assign acc = req & ack_r;
   assign wr = acc & wb_we_i & wb_sel_i[0];
   assign rd = acc & ~wb_we_i;
   assign ctrl_acc = acc & (wb_adr_i == `DCMP_OFF_CTRL);
   assign ctrl_rd = ctrl_acc & ~wb_we_i;
   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdat_r;

   // Ack one cycle after the request, dropped the cycle after
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= req & ~ack_r;
      end
   end

   // Comparator enables from the configurable mode mapping
   assign on = {MODE_ON2[ctrl_r.mode], MODE_ON1[ctrl_r.mode]};

   // Analog input steering seen by the front end
   always_comb begin
      amux.cmp_on = on;
      amux.pos_from_ref = (ctrl_r.mode == `DCMP_MODE_FOUR);
      amux.neg_from_ref_pins = (ctrl_r.mode == `DCMP_MODE_FOUR) & ctrl_r.input_switch_select;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Two-flop synchroniser for the comparator relations
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         above_s1_r <= 2'h0;
         above_s2_r <= 2'h0;
      end else begin
         above_s1_r <= cmp_above;
         above_s2_r <= above_s1_r;
      end
   end

   // Two-flop synchroniser for the port pin levels
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pin_s1_r <= 6'h00;
         pin_s2_r <= 6'h00;
      end else begin
         pin_s1_r <= port_pin_in;
         pin_s2_r <= pin_s1_r;
      end
   end

   assign res = cmp_res(above_s2_r, ctrl_r, on);
   assign raw_res = cmp_res(cmp_above, ctrl_r, on);

   // Routed pins carry the unsynchronised result
   assign first_output_pin = MODE_ROUTE[ctrl_r.mode] & raw_res[0];
   assign second_output_pin = MODE_ROUTE[ctrl_r.mode] & raw_res[1];
   // Direction bit low means driver on, only while the pin is routed
   assign first_output_pin_oe = MODE_ROUTE[ctrl_r.mode] & ~dir_r[4];
   assign second_output_pin_oe = MODE_ROUTE[ctrl_r.mode] & ~dir_r[5];

   ////////////////////////////////////////////////////////////////////////////
   // Control register; sleep has no effect on it
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl_r <= `DCMP_CTRL_RST;
      end else if (wr && wb_adr_i == `DCMP_OFF_CTRL) begin
         ctrl_r <= wb_dat_i[5:0];
      end
   end

   // Result copy taken at every control access
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         seen_r <= 2'h0;
      end else if (ctrl_acc) begin
         seen_r <= res;
      end
   end

   assign mism = res ^ seen_r;

   // Change flag: set wins over clear; a control read in that cycle drops it
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         flag_r <= 1'b0;
      end else if ((|mism) && !ctrl_rd) begin
         flag_r <= 1'b1;
      end else if (wr && wb_adr_i == `DCMP_OFF_REQ2) begin
         flag_r <= wb_dat_i[`DCMP_BIT_FLAG];
      end
   end

   // Comparator interrupt enable
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         comparator_irq_enable_r <= 1'b0;
      end else if (wr && wb_adr_i == `DCMP_OFF_EN2) begin
         comparator_irq_enable_r <= wb_dat_i[`DCMP_BIT_COMPARATOR_IRQ_ENABLE];
      end
   end

   // Global and peripheral interrupt enables
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         gie_r <= 1'b0;
         peripheral_irq_enable_r <= 1'b0;
      end else if (wr && wb_adr_i == `DCMP_OFF_INTC) begin
         gie_r <= wb_dat_i[`DCMP_BIT_GIE];
         peripheral_irq_enable_r <= wb_dat_i[`DCMP_BIT_PERIPHERAL_IRQ_ENABLE];
      end
   end

   // Port direction; a set bit makes the pin an input
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         dir_r <= `DCMP_DIR_RST;
      end else if (wr && wb_adr_i == `DCMP_OFF_DIR) begin
         dir_r <= wb_dat_i[5:0];
      end
   end

   // Pin configuration; every shared pin analog after reset
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pcfg_r <= `DCMP_PCFG_RST;
      end else if (wr && wb_adr_i == `DCMP_OFF_CONV1) begin
         pcfg_r <= wb_dat_i[3:0];
      end
   end

   // Clear config bit means analog pin
   assign pin_analog = ~pcfg_r;
   assign irq = flag_r & comparator_irq_enable_r & peripheral_irq_enable_r & gie_r;
   assign wake = flag_r & comparator_irq_enable_r;

   ////////////////////////////////////////////////////////////////////////////
   // Read data mux; unmapped offsets read zero
   always_comb begin
      rdat_nxt = 32'h0;
      case (wb_adr_i)
         `DCMP_OFF_CTRL: rdat_nxt[7:0] = {res, ctrl_r};
         `DCMP_OFF_REQ2: rdat_nxt[`DCMP_BIT_FLAG] = flag_r;
         `DCMP_OFF_EN2: rdat_nxt[`DCMP_BIT_COMPARATOR_IRQ_ENABLE] = comparator_irq_enable_r;
         `DCMP_OFF_INTC: rdat_nxt[7:6] = {gie_r, peripheral_irq_enable_r};
         `DCMP_OFF_DIR: rdat_nxt[5:0] = dir_r;
         `DCMP_OFF_CONV1: rdat_nxt[3:0] = pcfg_r;
         `DCMP_OFF_PORT: rdat_nxt[5:0] = pin_s2_r & {2'h3, ~pin_analog};
         default: rdat_nxt = 32'h0;
      endcase
   end

   // Read data captured with the ack
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rdat_r <= 32'h0;
      end else if (req && !ack_r) begin
         rdat_r <= rdat_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   sequence ctrl_write_s;
      wr && wb_adr_i == `DCMP_OFF_CTRL;
   endsequence

   sequence change_s;
      (|mism) && !ctrl_rd;
   endsequence

   flag_sets_a: assert property (change_s |=> flag_r)
      else $error("flag missed a result change");
   flag_race_a: assert property (ctrl_rd && !flag_r && !(wr) |=> !flag_r)
      else $error("flag set during control read");
   match_clear_a: assert property (ctrl_acc |=> mism == (res ^ $past(res)))
      else $error("mismatch not cleared by access");
   ro_bits_a: assert property (ctrl_write_s |=> ctrl_r == $past(wb_dat_i[5:0]))
      else $error("control write wrong");
   soft_set_a: assert property (wr && wb_adr_i == `DCMP_OFF_REQ2 && wb_dat_i[6] |=> flag_r)
      else $error("software set lost");
   flag_hold_a: assert property (flag_r && !(wr && wb_adr_i == `DCMP_OFF_REQ2) |=> flag_r)
      else $error("flag dropped by itself");
   irq_gate_a: assert property (irq == (flag_r && comparator_irq_enable_r && peripheral_irq_enable_r && gie_r))
      else $error("interrupt gating wrong");
   off_mode_a: assert property (ctrl_r.mode == `DCMP_MODE_OFF |-> res == 2'h0)
      else $error("off mode result not low");
   ref_pos_a: assert property (amux.pos_from_ref == (ctrl_r.mode == `DCMP_MODE_FOUR))
      else $error("reference steering wrong");
   route_oe_a: assert property (first_output_pin_oe |-> !dir_r[4])
      else $error("pin driven with direction input");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");
   port_zero_a: assert property (req && !ack_r && wb_adr_i == `DCMP_OFF_PORT
      |=> (wb_dat_o[3:0] & $past(pin_analog)) == 4'h0)
      else $error("analog pin read nonzero");

   // Edges since reset, saturating; the sync checks wait for a full pipe
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         age_r <= 2'h0;
      end else if (age_r != 2'h3) begin
         age_r <= age_r + 2'h1;
      end
   end

   // Request edge, then a one-cycle ack
   sequence bus_req_s;
      req && !ack_r;
   endsequence

   sequence bus_done_s;
      wb_ack_o ##1 !wb_ack_o;
   endsequence

   // Software write of zero to the change flag
   sequence clear_write_s;
      wr && wb_adr_i == `DCMP_OFF_REQ2 && !wb_dat_i[`DCMP_BIT_FLAG];
   endsequence

   // Bus handshake
   ack_follow_a: assert property (bus_req_s |=> bus_done_s)
      else $error("ack not one cycle after request");
   ack_idle_a: assert property (!req |=> !wb_ack_o)
      else $error("ack without request");

   // Enable registers and interrupt gating
   comparator_irq_enable_write_a: assert property (wr && wb_adr_i == `DCMP_OFF_EN2
      |=> comparator_irq_enable_r == $past(wb_dat_i[`DCMP_BIT_COMPARATOR_IRQ_ENABLE]))
      else $error("enable write lost");
   irq_mask_a: assert property (!comparator_irq_enable_r || !peripheral_irq_enable_r || !gie_r |-> !irq)
      else $error("interrupt passed a clear enable");
   wake_gate_a: assert property (flag_r && comparator_irq_enable_r |-> wake)
      else $error("wake missing while flag enabled");

   // Flag clear holds only once the mismatch has ended
   flag_clear_a: assert property (clear_write_s ##0 !(|mism) |=> !flag_r)
      else $error("flag clear ignored");
   clear_refused_a: assert property (clear_write_s ##0 (|mism) |=> flag_r)
      else $error("flag cleared during mismatch");

   // Control register changes only by a control write
   ctrl_stable_a: assert property (!(wr && wb_adr_i == `DCMP_OFF_CTRL)
      |=> $stable(ctrl_r))
      else $error("control register changed without write");

   // Mode decode: off mode, reference steering, input switch
   off_enable_a: assert property (ctrl_r.mode == `DCMP_MODE_OFF
      |-> amux.cmp_on == 2'h0)
      else $error("comparator on in off mode");
   ref_only_four_a: assert property (ctrl_r.mode != `DCMP_MODE_FOUR
      |-> !amux.pos_from_ref && !amux.neg_from_ref_pins)
      else $error("reference steering outside mode 110");
   neg_ref_a: assert property (amux.neg_from_ref_pins
      |-> ctrl_r.mode == `DCMP_MODE_FOUR && ctrl_r.input_switch_select)
      else $error("input switch steering wrong");

   // Pin routing follows the mode map and the direction bits
   route_off_a: assert property (!MODE_ROUTE[ctrl_r.mode]
      |-> !first_output_pin && !second_output_pin
      && !first_output_pin_oe && !second_output_pin_oe)
      else $error("pin driven while not routed");
   route_oe2_a: assert property (second_output_pin_oe |-> !dir_r[5])
      else $error("second pin driven as input");
   route_dir_a: assert property (MODE_ROUTE[ctrl_r.mode] && !dir_r[4]
      |-> first_output_pin_oe)
      else $error("routed output pin not driven");

   // Direction and pin configuration writes land as written
   dir_write_a: assert property (wr && wb_adr_i == `DCMP_OFF_DIR
      |=> dir_r == $past(wb_dat_i[5:0]))
      else $error("direction write lost");
   pcfg_write_a: assert property (wr && wb_adr_i == `DCMP_OFF_CONV1
      |=> pin_analog == ~$past(wb_dat_i[3:0]))
      else $error("pin configuration write lost");

   // Inversion flips a running comparator only
   inv_first_a: assert property (amux.cmp_on[0]
      |-> res[0] == (above_s2_r[0] ^ ctrl_r.inv1))
      else $error("first result polarity wrong");
   inv_second_a: assert property (amux.cmp_on[1]
      |-> res[1] == (above_s2_r[1] ^ ctrl_r.inv2))
      else $error("second result polarity wrong");

   // Both synchronisers deliver their input two edges late
   cmp_sync_a: assert property (age_r == 2'h3 |-> above_s2_r == $past(cmp_above, 2))
      else $error("comparator synchroniser skewed");
   port_sync_a: assert property (age_r == 2'h3 |-> pin_s2_r == $past(port_pin_in, 2))
      else $error("port synchroniser skewed");
endmodule

// file: verification/dcmp_analog_model.sv
// Analog side model: input levels per comparator, relation seen by the block
`timescale 1ns/1ps
module dcmp_analog_model (
   input wire logic [11:0] pos1_mv,
   input wire logic [11:0] neg1_mv,
   input wire logic [11:0] pos2_mv,
   input wire logic [11:0] neg2_mv,
   output logic [1:0] cmp_above
);
   // High only when positive input is above negative input
   assign cmp_above = {pos2_mv > neg2_mv, pos1_mv > neg1_mv};
endmodule

// file: verification/dcmp_core_bench.sv
// Register-level bench for the comparator block
`timescale 1ns/1ps
`include "dcmp_defines.svh"
module dcmp_core_bench;
   import dcmp_pkg::*;
   logic mclk = 0, rst = 1, cyc = 0, we = 0;
   logic [4:0] adr = 5'h00;
   logic [31:0] dat = 32'h0, dat_o;
   logic ack, p1, p1_oe, p2, p2_oe, irq, wake;
   logic [1:0] above;
   logic [5:0] pins = 6'h3f;
   logic [3:0] pin_analog;
   logic [11:0] v1p = 12'h100, v1n = 12'h080, v2p = 12'h080, v2n = 12'h100;
   logic [7:0] q;
   dcmp_amux_type amux;
   int n_mismatch = 0, comparisons = 0, cycles = 0;
   dcmp_analog_model ana (.pos1_mv(v1p), .neg1_mv(v1n), .pos2_mv(v2p), .neg2_mv(v2n),
      .cmp_above(above));
   dcmp_core #(.MODE_ROUTE(8'h01)) DUT (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc),
      .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .cmp_above(above), .port_pin_in(pins),
      .first_output_pin(p1), .first_output_pin_oe(p1_oe), .second_output_pin(p2),
      .second_output_pin_oe(p2_oe), .amux(amux), .pin_analog(pin_analog), .irq(irq),
      .wake(wake));
   // Clock and hang guard
   always #5 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         n_mismatch++;
         print_verdict();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One classic cycle, held until ack is sampled high
   task automatic wb(input logic [4:0] a, input logic w, input logic [7:0] d);
      @(posedge mclk);
      cyc <= 1;
      we <= w;
      adr <= a;
      dat <= {24'h0, d};
      do begin
         @(posedge mclk);
      end while (ack !== 1'b1);
      q = dat_o[7:0];
      cyc <= 0;
      @(negedge mclk);
   endtask
   task automatic rd(input logic [4:0] a, input logic [7:0] exp);
      wb(a, 0, 8'h00);
      check(q, exp);
   endtask
   task automatic print_verdict();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (5) @(posedge mclk);
      rst <= 0;
      rd(`DCMP_OFF_CTRL, 8'h07);
      rd(`DCMP_OFF_DIR, 8'h3f);
      check(pin_analog, 4'hf);
      rd(`DCMP_OFF_PORT, 8'h30);
      wb(`DCMP_OFF_CTRL, 1, 8'hc0);
      repeat (4) @(posedge mclk);
      rd(`DCMP_OFF_CTRL, 8'h40);
      check(amux.cmp_on, 2'b11);
      check({p2, p1, p2_oe, p1_oe}, 4'h4);
      wb(`DCMP_OFF_DIR, 1, 8'h00);
      check({p2_oe, p1_oe}, 2'b11);
      wb(`DCMP_OFF_CTRL, 1, 8'h30);
      repeat (4) @(posedge mclk);
      rd(`DCMP_OFF_CTRL, 8'hb0);
      check({p2, p1, p2_oe, p1_oe}, 4'hb);
      wb(`DCMP_OFF_REQ2, 1, 8'h00);
      rd(`DCMP_OFF_REQ2, 8'h00);
      @(posedge mclk);
      v2p <= 12'h200;
      #1 check({p2, p1}, 2'b00);
      repeat (4) @(posedge mclk);
      rd(`DCMP_OFF_REQ2, 8'h40);
      wb(`DCMP_OFF_REQ2, 1, 8'h00);
      rd(`DCMP_OFF_REQ2, 8'h40);
      rd(`DCMP_OFF_CTRL, 8'h30);
      wb(`DCMP_OFF_REQ2, 1, 8'h00);
      rd(`DCMP_OFF_REQ2, 8'h00);
      wb(`DCMP_OFF_REQ2, 1, 8'h40);
      rd(`DCMP_OFF_REQ2, 8'h40);
      check({irq, wake}, 2'b00);
      wb(`DCMP_OFF_EN2, 1, 8'h40);
      check({irq, wake}, 2'b01);
      wb(`DCMP_OFF_INTC, 1, 8'hc0);
      check({irq, wake}, 2'b11);
      wb(`DCMP_OFF_INTC, 1, 8'h00);
      wb(`DCMP_OFF_CTRL, 1, 8'h0e);
      check({amux.pos_from_ref, amux.neg_from_ref_pins}, 2'b11);
      wb(`DCMP_OFF_CTRL, 1, 8'h06);
      check({amux.pos_from_ref, amux.neg_from_ref_pins}, 2'b10);
      // Mid-run reset must restore the off mode and analog pins
      @(posedge mclk);
      rst <= 1;
      repeat (2) @(posedge mclk);
      rst <= 0;
      rd(`DCMP_OFF_CTRL, 8'h07);
      check(pin_analog, 4'hf);
      wb(`DCMP_OFF_CTRL, 1, 8'h07);
      check(amux.cmp_on, 2'b00);
      wb(`DCMP_OFF_CONV1, 1, 8'h0f);
      check(pin_analog, 4'h0);
      rd(`DCMP_OFF_PORT, 8'h3f);
      print_verdict();
   end
endmodule
